// [bench/fault_event_status_bank_test.sv]
// Self-checking bench for the fault and event status bank.
// Assumes the host model in host_reader and a 25 MHz control clock.
`timescale 1ns/100ps

module fault_event_status_bank_test
    import fault_status_pkg::*;
;
    localparam int LIMIT = 5000; // Cycle ceiling, run needs under 1500
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    diag_pins_t pins = '0; // Detector levels
    logic [7:0] inOneMask = 8'h00;
    logic [7:0] inTwoMask = 8'h00;
    logic [3:0] outOneMask = 4'h0;
    logic [3:0] outTwoMask = 4'h0;
    reg_req_t req;
    logic [7:0] rdata;
    logic rvalid;
    int failCount = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h0000_c4f6;
    logic [31:0] r;
    logic [31:0] m;
    logic [7:0] v;

    // ************************************************************
    // Clock, instances, watchdog
    // ************************************************************
    always #20 clk = ~clk;

    fault_event_status_bank uut (.clk(clk), .arst_n(arst_n), .diagPins(pins),
        .inOneMask(inOneMask), .inTwoMask(inTwoMask), .outOneMask(outOneMask),
        .outTwoMask(outTwoMask), .regReq(req), .regRdata(rdata), .regRvalid(rvalid));

    host_reader host (.clk(clk), .regRdata(rdata), .regRvalid(rvalid), .regReq(req));

    // Cuts a hang short
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            failCount++;
            finishTest();
        end
    end

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Summary byte from levels and masks now applied
    function automatic logic [7:0] sumExp();
        return {|(pins.inOneFault & ~inOneMask), |(pins.inTwoFault & ~inTwoMask),
            |(pins.outOneFault & ~outOneMask), |(pins.outTwoFault & ~outTwoMask),
            |pins.vbatLowShort, RESERVED_ZERO};
    endfunction

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Read one byte and compare
    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [7:0] d;
        logic ok;
        host.readReg(a, d, ok);
        comparisons++;
        if (ok !== 1'b1 || d !== exp)
        begin
            $display("unexpected at %0t: %s read %h expected %h", $time, what, d, exp);
            failCount++;
        end
    endtask

    task automatic finishTest();
        $display("comparisons %0d, mismatches %0d", comparisons, failCount);
        if (failCount == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        settle(2);
        arst_n <= 1'b1;
        settle(4);
        // Reset values, unmapped place
        rdChk(LATCHED_EVENT_STATUS_TWO_ADDR, REG_RESET, "latched reset");
        rdChk(LIVE_EVENT_STATUS_ADDR, REG_RESET, "live reset");
        rdChk(CHANNEL_FAULT_SUMMARY_ADDR, REG_RESET, "summary reset");
        rdChk(INPUT_ONE_FAULT_LIVE_ADDR, REG_RESET, "input one reset");
        rdChk(8'h42, 8'h00, "unmapped");
        $display("test reset values done");
        // Each latched source in turn: short pulse, then self clear on read
        for (int i = 0; i < 8; i++)
        begin
            pins.latchSrc <= 8'h01 << i;
            settle(2);
            pins.latchSrc <= 8'h00;
            settle(4);
            rdChk(LATCHED_EVENT_STATUS_TWO_ADDR, 8'h01 << i, "latch");
            rdChk(LATCHED_EVENT_STATUS_TWO_ADDR, 8'h00, "latch clear");
        end
        // Source held high through a read: the set must win
        r = rnd() | 32'h0000_0081;
        v = r[7:0];
        pins.latchSrc <= v;
        settle(4);
        rdChk(LATCHED_EVENT_STATUS_TWO_ADDR, v, "latch held");
        pins.latchSrc <= 8'h00;
        settle(4);
        // A write of the reset value neither clears nor sets
        host.writeReg(LATCHED_EVENT_STATUS_TWO_ADDR, REG_RESET);
        rdChk(LATCHED_EVENT_STATUS_TWO_ADDR, v, "latch kept");
        rdChk(LATCHED_EVENT_STATUS_TWO_ADDR, 8'h00, "latch gone");
        // Mid-run reset wipes a pending event; live level comes back after
        pins.latchSrc <= 8'hA5;
        pins.liveSrc <= 5'h15;
        settle(2);
        pins.latchSrc <= 8'h00;
        settle(4);
        rdChk(LIVE_EVENT_STATUS_ADDR, {5'h15, RESERVED_ZERO}, "live before reset");
        arst_n <= 1'b0;
        settle(2);
        comparisons++;
        if (rdata !== REG_RESET || rvalid !== 1'b0)
        begin
            $display("unexpected at %0t: read port not idle in reset", $time);
            failCount++;
        end
        arst_n <= 1'b1;
        settle(4);
        rdChk(LATCHED_EVENT_STATUS_TWO_ADDR, REG_RESET, "latched after reset");
        rdChk(LIVE_EVENT_STATUS_ADDR, {5'h15, RESERVED_ZERO}, "live after reset");
        $display("test mid-run reset done");
        $display("test latched events done");
        // Live flags follow the source and survive reads
        for (int k = 0; k < 8; k++)
        begin
            r = (k == 0) ? 32'h1F : rnd();
            pins.liveSrc <= r[4:0];
            settle(4);
            rdChk(LIVE_EVENT_STATUS_ADDR, {r[4:0], RESERVED_ZERO}, "live");
            rdChk(LIVE_EVENT_STATUS_ADDR, {r[4:0], RESERVED_ZERO}, "live again");
        end
        // A write to a read-only byte changes nothing
        host.writeReg(LIVE_EVENT_STATUS_ADDR, ~{r[4:0], RESERVED_ZERO});
        rdChk(LIVE_EVENT_STATUS_ADDR, {r[4:0], RESERVED_ZERO}, "live after write");
        pins.liveSrc <= 5'h00;
        settle(4);
        rdChk(LIVE_EVENT_STATUS_ADDR, 8'h00, "live dropped");
        $display("test live events done");
        // Channel summary and input one byte, all masked first, then random
        for (int k = 0; k < 16; k++)
        begin
            r = (k == 0) ? 32'hFFFF_FFFF : rnd();
            m = (k == 0) ? 32'hFFFF_FFFF : rnd() & rnd();
            pins.inOneFault <= r[7:0];
            pins.inTwoFault <= r[15:8];
            pins.outOneFault <= r[19:16];
            pins.outTwoFault <= r[23:20];
            pins.vbatLowShort <= r[25:24];
            inOneMask <= m[7:0];
            inTwoMask <= m[15:8];
            outOneMask <= m[19:16];
            outTwoMask <= m[23:20];
            settle(4);
            rdChk(CHANNEL_FAULT_SUMMARY_ADDR, sumExp(), "summary");
            rdChk(INPUT_ONE_FAULT_LIVE_ADDR, r[7:0], "input one");
        end
        $display("test channel faults done");
        finishTest();
    end
endmodule // fault_event_status_bank_test

// [bench/host_reader.sv]
// Host side of the register port: single byte reads and writes.
// Assumes strobes are taken at a rising clk edge and answered one edge later.
`timescale 1ns/100ps

module host_reader
    import fault_status_pkg::*;
(
    input wire logic clk,
    input wire logic [7:0] regRdata,
    input wire logic regRvalid,
    output reg_req_t regReq
);
    // ************************************************************
    // Request driver
    // ************************************************************
    // Idle at time zero
    initial regReq = '{rd: 1'b0, wr: 1'b0, addr: 8'h00, wdata: 8'h00};

    // One read; ok low unless valid comes one edge after the strobe,
    // stands one cycle only, and the data then holds
    task automatic readReg(input logic [7:0] a, output logic [7:0] d, output logic ok);
        ok = 1'b0;
        d = 8'h00;
        @(posedge clk);
        regReq <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: ~a};
        @(posedge clk);
        // Scrambled when released, so a stale address cannot pass
        regReq <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: a};
        @(posedge clk);
        // Data taken at the edge that sees valid, exactly one cycle on
        d = regRdata;
        ok = (regRvalid === 1'b1);
        @(posedge clk);
        // A stuck valid, or data moving without a read, is a fault
        if (regRvalid !== 1'b0 || regRdata !== d)
        begin
            ok = 1'b0;
        end
    endtask

    // One write; reserved low bits are sent as zero
    task automatic writeReg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regReq <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: {d[7:3], RESERVED_ZERO}};
        @(posedge clk);
        regReq <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask
endmodule // host_reader

// [design/fault_event_status_bank.sv]
// Fault and event status bank: latched self-clearing events, live flags,
// per-channel summary and the input one live fault byte.
// Assumes the control port slave presents one-cycle strobes on clk and
// that detector levels and masks arrive as described at the ports.
`timescale 1ns/100ps

module fault_event_status_bank
    import fault_status_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire diag_pins_t diagPins,
    input wire logic [CHAN_W-1:0] inOneMask,
    input wire logic [CHAN_W-1:0] inTwoMask,
    input wire logic [OUT_FAULT_W-1:0] outOneMask,
    input wire logic [OUT_FAULT_W-1:0] outTwoMask,
    input wire reg_req_t regReq,
    output logic [7:0] regRdata,
    output logic regRvalid
);

    // ************************************************************
    // Reset release
    // ************************************************************
    logic [1:0] rstSync; // Release synchroniser
    logic rst_n; // Synchronised reset used everywhere below

    // Asynchronous assert, two-flop release so no flop sees a runt
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rstSync <= 2'h0;
        end
        else
        begin
            rstSync <= {rstSync[0], 1'b1};
        end
    end
    assign rst_n = rstSync[1];

    // ************************************************************
    // Detector synchronisers
    // ************************************************************
    diag_pins_t pinMeta; // First stage, read only by second stage
    diag_pins_t pinSync; // Safe copy of detector levels

    // Two flops; detectors run in analog domains with no clock relation
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pinMeta <= '0;
            pinSync <= '0;
        end
        else
        begin
            pinMeta <= diagPins;
            pinSync <= pinMeta;
        end
    end

    // ************************************************************
    // Decode helpers
    // ************************************************************
    // Read strobe hitting one offset
    function automatic logic readHit(input reg_req_t req, input logic [7:0] offs);
        readHit = req.rd && (req.addr == offs);
    endfunction

    // OR of fault flags that survive their masks
    function automatic logic anyUnmasked(input logic [CHAN_W-1:0] flags,
                                         input logic [CHAN_W-1:0] mask);
        anyUnmasked = |(flags & ~mask);
    endfunction

    // ************************************************************
    // Latched event register
    // ************************************************************
    logic [7:0] latchedEventStatusTwo; // Sticky event flags
    logic latchClear; // Read of the latched register
    logic [7:0] latchSet; // Event inputs this cycle
    logic [7:0] next_latched; // Next sticky value

    assign latchClear = readHit(regReq, LATCHED_EVENT_STATUS_TWO_ADDR);

    // Map each detector to its bit
    always_comb
    begin
        latchSet = REG_RESET;
        latchSet[LAT_MONITOR_HIGH] = pinSync.latchSrc[LAT_MONITOR_HIGH];
        latchSet[LAT_MONITOR_LOW] = pinSync.latchSrc[LAT_MONITOR_LOW];
        latchSet[LAT_VOICE_UP] = pinSync.latchSrc[LAT_VOICE_UP];
        latchSet[LAT_VOICE_DOWN] = pinSync.latchSrc[LAT_VOICE_DOWN];
        latchSet[LAT_BIAS_SHORT] = pinSync.latchSrc[LAT_BIAS_SHORT];
        latchSet[LAT_BIAS_HIGH_CUR] = pinSync.latchSrc[LAT_BIAS_HIGH_CUR];
        latchSet[LAT_BIAS_LOW_CUR] = pinSync.latchSrc[LAT_BIAS_LOW_CUR];
        latchSet[LAT_BIAS_OVER_VOLT] = pinSync.latchSrc[LAT_BIAS_OVER_VOLT];
    end

    // Set beats clear so an event landing on the read is kept for next read
    always_comb
    begin
        if (latchClear)
        begin
            next_latched = latchSet;
        end
        else
        begin
            next_latched = latchedEventStatusTwo | latchSet;
        end
    end

    // Sticky flag storage
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            latchedEventStatusTwo <= REG_RESET;
        end
        else
        begin
            latchedEventStatusTwo <= next_latched;
        end
    end

    // ************************************************************
    // Live registers
    // ************************************************************
    logic [7:0] liveEventStatus; // Live event flags
    logic [7:0] channelFaultSummary; // Per-channel fault summary
    logic [7:0] inputOneFaultLive; // Input one live faults
    logic [7:0] next_summary; // Next summary value

    // Summary bits from unmasked channel flags
    always_comb
    begin
        next_summary = REG_RESET;
        next_summary[SUM_IN_ONE] = anyUnmasked(pinSync.inOneFault, inOneMask);
        next_summary[SUM_IN_TWO] = anyUnmasked(pinSync.inTwoFault, inTwoMask);
        next_summary[SUM_OUT_ONE] = |(pinSync.outOneFault & ~outOneMask);
        next_summary[SUM_OUT_TWO] = |(pinSync.outTwoFault & ~outTwoMask);
        next_summary[SUM_VBAT] = |pinSync.vbatLowShort;
    end

    // Live flags track their sources and never clear on read
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            liveEventStatus <= REG_RESET;
            channelFaultSummary <= REG_RESET;
            inputOneFaultLive <= REG_RESET;
        end
        else
        begin
            liveEventStatus <= {pinSync.liveSrc, RESERVED_ZERO};
            channelFaultSummary <= next_summary;
            inputOneFaultLive <= pinSync.inOneFault;
        end
    end

    // ************************************************************
    // Read port
    // ************************************************************
    logic [7:0] next_rdata; // Selected read data

    // Address decode; writes are dropped, unmapped reads give zero
    always_comb
    begin
        if (readHit(regReq, LATCHED_EVENT_STATUS_TWO_ADDR))
        begin
            next_rdata = latchedEventStatusTwo; // Value before the clear
        end
        else if (readHit(regReq, LIVE_EVENT_STATUS_ADDR))
        begin
            next_rdata = liveEventStatus;
        end
        else if (readHit(regReq, CHANNEL_FAULT_SUMMARY_ADDR))
        begin
            next_rdata = channelFaultSummary;
        end
        else if (readHit(regReq, INPUT_ONE_FAULT_LIVE_ADDR))
        begin
            next_rdata = inputOneFaultLive;
        end
        else
        begin
            next_rdata = REG_RESET; // Unmapped or no read
        end
    end

    // Data held until the next read; valid pulses one cycle
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            regRdata <= REG_RESET;
            regRvalid <= 1'b0;
        end
        else
        begin
            regRvalid <= regReq.rd;
            if (regReq.rd)
            begin
                regRdata <= next_rdata;
            end
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    // A raised source shows in the sticky byte one edge later
    property p_latch_set;
        @(posedge clk) disable iff (!rst_n)
        (pinSync.latchSrc != REG_RESET) |=>
            ((latchedEventStatusTwo & $past(pinSync.latchSrc)) == $past(pinSync.latchSrc));
    endproperty
    a_latch_set: assert property (p_latch_set)
        else $error("latched event not captured");

    // A read with every source low empties the sticky byte
    property p_latch_clear;
        @(posedge clk) disable iff (!rst_n)
        (latchClear && pinSync.latchSrc == REG_RESET) |=> (latchedEventStatusTwo == REG_RESET);
    endproperty
    a_latch_clear: assert property (p_latch_clear)
        else $error("latched register not cleared by read");

    // No sticky bit drops unless the byte was read
    property p_latch_hold;
        @(posedge clk) disable iff (!rst_n)
        !latchClear |=>
            ((latchedEventStatusTwo & $past(latchedEventStatusTwo)) == $past(latchedEventStatusTwo));
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("latched flag dropped without read");

    // Live bits copy the synchronised sources, one edge late
    property p_live_follow;
        @(posedge clk) disable iff (!rst_n)
        ##1 liveEventStatus[7:3] == $past(pinSync.liveSrc);
    endproperty
    a_live_follow: assert property (p_live_follow)
        else $error("live flags do not follow sources");

    // Reserved low bits never rise
    property p_reserved_zero;
        @(posedge clk) disable iff (!rst_n)
        liveEventStatus[2:0] == RESERVED_ZERO && channelFaultSummary[2:0] == RESERVED_ZERO;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits not zero");

    // Input one summary bit from its unmasked flags
    property p_summary_in_one;
        @(posedge clk) disable iff (!rst_n)
        ##1 channelFaultSummary[SUM_IN_ONE] == $past(|(pinSync.inOneFault & ~inOneMask));
    endproperty
    a_summary_in_one: assert property (p_summary_in_one)
        else $error("input one summary wrong");

    // Battery short bit from either input channel
    property p_summary_vbat;
        @(posedge clk) disable iff (!rst_n)
        ##1 channelFaultSummary[SUM_VBAT] == $past(|pinSync.vbatLowShort);
    endproperty
    a_summary_vbat: assert property (p_summary_vbat)
        else $error("battery short summary wrong");

    // Input one byte copies its detector levels
    property p_in_one_live;
        @(posedge clk) disable iff (!rst_n)
        ##1 inputOneFaultLive == $past(pinSync.inOneFault);
    endproperty
    a_in_one_live: assert property (p_in_one_live)
        else $error("input one live byte wrong");

    // Live read returns the byte standing at the strobe
    property p_read_live;
        @(posedge clk) disable iff (!rst_n)
        readHit(regReq, LIVE_EVENT_STATUS_ADDR) |=>
            (regRvalid && regRdata == $past(liveEventStatus));
    endproperty
    a_read_live: assert property (p_read_live)
        else $error("live register read wrong");

    // Latched read returns the value before the clear
    property p_read_latched;
        @(posedge clk) disable iff (!rst_n)
        latchClear |=> (regRvalid && regRdata == $past(latchedEventStatusTwo));
    endproperty
    a_read_latched: assert property (p_read_latched)
        else $error("latched register read wrong");

    // Offsets outside the bank read as zero
    property p_read_unmapped;
        @(posedge clk) disable iff (!rst_n)
        (regReq.rd && (regReq.addr < LATCHED_EVENT_STATUS_TWO_ADDR
                       || regReq.addr > INPUT_ONE_FAULT_LIVE_ADDR)) |=> regRdata == REG_RESET;
    endproperty
    a_read_unmapped: assert property (p_read_unmapped)
        else $error("unmapped read not zero");

    // Summary read returns the byte standing at the strobe
    property p_read_summary;
        @(posedge clk) disable iff (!rst_n)
        readHit(regReq, CHANNEL_FAULT_SUMMARY_ADDR) |=>
            (regRvalid && regRdata == $past(channelFaultSummary));
    endproperty
    a_read_summary: assert property (p_read_summary)
        else $error("summary register read wrong");

    // Input two and output summary bits follow their unmasked flags
    property p_summary_others;
        @(posedge clk) disable iff (!rst_n)
        ##1 channelFaultSummary[SUM_IN_TWO] == $past(|(pinSync.inTwoFault & ~inTwoMask))
            && channelFaultSummary[SUM_OUT_ONE] == $past(|(pinSync.outOneFault & ~outOneMask))
            && channelFaultSummary[SUM_OUT_TWO] == $past(|(pinSync.outTwoFault & ~outTwoMask));
    endproperty
    a_summary_others: assert property (p_summary_others)
        else $error("input two or output summary wrong");

    // Input one byte read returns the byte standing at the strobe
    property p_read_in_one;
        @(posedge clk) disable iff (!rst_n)
        readHit(regReq, INPUT_ONE_FAULT_LIVE_ADDR) |=>
            (regRvalid && regRdata == $past(inputOneFaultLive));
    endproperty
    a_read_in_one: assert property (p_read_in_one)
        else $error("input one register read wrong");

endmodule // fault_event_status_bank

// [design/fault_status_pkg.sv]
// Package for the fault and event status bank: offsets, bit positions,
// reset values and the packed carriers for detector inputs and read requests.
// Assumes one control clock shared by the bank and its register port.
package fault_status_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] LATCHED_EVENT_STATUS_TWO_ADDR = 8'h3B; // Latched events
    localparam logic [7:0] LIVE_EVENT_STATUS_ADDR = 8'h3C; // Live events
    localparam logic [7:0] CHANNEL_FAULT_SUMMARY_ADDR = 8'h3D; // Channel summary
    localparam logic [7:0] INPUT_ONE_FAULT_LIVE_ADDR = 8'h3E; // Input one faults

    // ************************************************************
    // Reset values and widths
    // ************************************************************
    localparam logic [7:0] REG_RESET = 8'h00; // Every register resets to zero
    localparam logic [2:0] RESERVED_ZERO = 3'h0; // Reserved low bits
    localparam int LIVE_SRC_W = 5; // Live event sources
    localparam int OUT_FAULT_W = 4; // Output channel fault bits
    localparam int CHAN_W = 8; // Input channel fault bits

    // ************************************************************
    // Bit positions, latched event register
    // ************************************************************
    localparam int LAT_MONITOR_HIGH = 7; // Analog monitor over upper threshold
    localparam int LAT_MONITOR_LOW = 6; // Analog monitor under lower threshold
    localparam int LAT_VOICE_UP = 5; // Voice activity power-up detect
    localparam int LAT_VOICE_DOWN = 4; // Voice activity power-down detect
    localparam int LAT_BIAS_SHORT = 3; // Bias supply short circuit
    localparam int LAT_BIAS_HIGH_CUR = 2; // Bias supply high current
    localparam int LAT_BIAS_LOW_CUR = 1; // Bias supply low current
    localparam int LAT_BIAS_OVER_VOLT = 0; // Bias supply over voltage

    // ************************************************************
    // Bit positions, live event register (upper five bits)
    // ************************************************************
    localparam int LIVE_CLOCK_ERR = 4; // Source index: clock error
    localparam int LIVE_PLL_LOCK = 3; // Source index: pll lock
    localparam int LIVE_BOOST_TEMP = 2; // Source index: boost over temperature
    localparam int LIVE_BOOST_CUR = 1; // Source index: boost over current
    localparam int LIVE_BOOST_MODE = 0; // Source index: boost_mode_indication

    // ************************************************************
    // Bit positions, channel summary register
    // ************************************************************
    localparam int SUM_IN_ONE = 7; // Any unmasked input one fault
    localparam int SUM_IN_TWO = 6; // Any unmasked input two fault
    localparam int SUM_OUT_ONE = 5; // Any unmasked output one fault
    localparam int SUM_OUT_TWO = 4; // Any unmasked output two fault
    localparam int SUM_VBAT = 3; // Battery short under bias, any channel

    // ************************************************************
    // Carriers
    // ************************************************************
    // Raw detector levels, all asynchronous to the control clock
    typedef struct packed {
        logic [CHAN_W-1:0] latchSrc; // Event sources of the latched register
        logic [LIVE_SRC_W-1:0] liveSrc; // Live event sources
        logic [CHAN_W-1:0] inOneFault; // Input one: open, shorts (bit 7..0)
        logic [CHAN_W-1:0] inTwoFault; // Input two faults, same layout
        logic [OUT_FAULT_W-1:0] outOneFault; // Output one faults
        logic [OUT_FAULT_W-1:0] outTwoFault; // Output two faults
        logic [1:0] vbatLowShort; // Per input channel, battery short under bias
    } diag_pins_t;

    // Read or write request from the control port
    typedef struct packed {
        logic rd; // One-cycle read strobe
        logic wr; // One-cycle write strobe
        logic [7:0] addr; // Register offset
        logic [7:0] wdata; // Write data, ignored by this read-only bank
    } reg_req_t;

endpackage : fault_status_pkg
